// >>> hw/fps_capture_record_read_cmd_store.sv
// Parameter capture record, flash commit and configuration store control
// Summary of operation
// - Bit 1 of misc configuration write turns capture mode on or off.
// - Record returns as one 32-byte block read; bus busy throughout.
// - Record readable during normal regulation, not only after a fault.
// - Capture enable accepted regardless of power output state.
// - With capture on, RAM record refreshed from live values every firmware cycle.
// - With capture off, RAM record is no longer refreshed.
// - Capture control value 1 copies flash record into RAM.
// - Capture control value 2 commits record to flash, only with output disabled.
// - Fault with shutdown response commits record to flash automatically.
// - Fault with retry response never commits to flash.
// - Flash commit finishes within 1400 us of its start.
// - Flash record survives power cycle and stays retrievable.
// - At initialization nonvolatile stores are checked for saved configuration.
// - Two nonvolatile configuration stores exist: default and user.
// - Restore default command reloads settings from the default store.
// - Restore only to levels made available; others are refused.
// - Voltages, current, temperature, frequency and duty readable by host.
`timescale 1ns/1ps
`default_nettype none
module fps_capture_record_read_cmd_store
  import fps_pkg::*;
#(
  parameter int COMMIT_CYC = COMMIT_CYCLES
) (
  input wire logic clock, // Core clock, 25 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic linkClk, // Host link clock
  input wire logic cmdValid, // Host command strobe, link domain
  input wire logic [7:0] cmdCode, // Host command code
  input wire logic [7:0] cmdData, // Host command data byte
  output logic cmdReady, // Link free for a new command
  output logic rdValid, // Read byte valid
  output logic [7:0] rdData, // Read byte
  output logic rdLast, // Last byte of block
  input wire logic fwTick, // Firmware cycle pulse, core domain
  input wire logic outputEnabled, // Power output running
  input wire logic faultEvent, // Fault threshold exceeded pulse
  input wire logic faultShutdown, // Fault response is shutdown
  input wire logic [1:0] levelAllowed, // Restore levels made available
  input wire logic defaultStoreValid, // Pin: default store holds data
  input wire logic userStoreValid, // Pin: user store holds data
  input wire logic [15:0] vin, // Input voltage
  input wire logic [15:0] vout, // Output voltage
  input wire logic [15:0] iout, // Output current
  input wire logic [15:0] temp, // Internal temperature
  input wire logic [15:0] freq, // Switching frequency
  input wire logic [15:0] duty, // Duty cycle
  output logic captureOn, // Capture mode state
  output logic commitBusy, // Flash commit in progress
  output logic nvmLoad, // Pulse: load settings from store
  output logic nvmStore, // Pulse: save settings to store
  output logic [1:0] nvmSel, // Store addressed by load or save
  output logic [1:0] activeConfig, // Store the settings came from
  output logic restoreRefused // Pulse: restore level blocked
);
  localparam int CW = $clog2(COMMIT_CYC + 1);
  // Live record: low bytes hold telemetry, upper bytes read zero
  logic [REC_BITS-1:0] liveRec;
  assign liveRec = {{(REC_BITS-TELEM_BITS){1'b0}}, duty, freq, temp, iout, vout, vin};
  fps_link_t lstate, next_lstate;
  logic lrs1, lrs2, ackS1, ackS2, ackSeen, reqToggle, ackToggle;
  logic [7:0] hCode, hData, next_hCode, next_hData, next_rdData;
  logic [4:0] byteIdx, next_byteIdx;
  logic next_reqToggle, next_ackSeen, next_cmdReady, next_rdValid, next_rdLast;
  logic [REC_BITS-1:0] readBuf;
  // Read-type commands come back as a block
  function automatic logic isRead(input logic [7:0] c);
    return (c == CMD_CAPTURE_READ) || (c == CMD_TELEM_READ);
  endfunction
  // Command handshake and block streaming; readBuf is held stable by the handshake
  always_comb begin
    next_lstate = lstate;
    next_hCode = hCode;
    next_hData = hData;
    next_reqToggle = reqToggle;
    next_ackSeen = ackSeen;
    next_cmdReady = cmdReady || (lstate == LK_IDLE); // Comes up once link reset ends
    next_rdValid = 1'b0;
    next_rdLast = 1'b0;
    next_rdData = rdData;
    next_byteIdx = byteIdx;
    unique case (lstate)
      LK_IDLE: begin
        if (cmdValid && cmdReady) begin
          next_hCode = cmdCode;
          next_hData = cmdData;
          next_reqToggle = ~reqToggle;
          next_cmdReady = 1'b0;
          next_lstate = LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (ackS2 != ackSeen) begin
          next_ackSeen = ackS2;
          if (isRead(hCode)) begin
            next_byteIdx = 5'h00;
            next_lstate = LK_SEND;
          end else begin
            next_cmdReady = 1'b1;
            next_lstate = LK_IDLE;
          end
        end
      end
      LK_SEND: begin
        // Bus stays occupied for all 32 bytes
        next_rdValid = 1'b1;
        next_rdData = readBuf[byteIdx*8 +: 8];
        next_byteIdx = byteIdx + 5'h01;
        if (byteIdx == 5'(BYTE_IDX_LAST)) begin
          next_rdLast = 1'b1;
          next_cmdReady = 1'b1;
          next_lstate = LK_IDLE;
        end
      end
      default: next_lstate = LK_IDLE;
    endcase
  end
  // Link registers; reset is brought over from the core domain
  always_ff @(posedge linkClk) begin
    lrs1 <= rst_b;
    lrs2 <= lrs1;
    ackS1 <= ackToggle;
    ackS2 <= ackS1;
    if (!lrs2) begin
      lstate <= LK_IDLE;
      hCode <= 8'h00;
      hData <= 8'h00;
      reqToggle <= 1'b0;
      ackSeen <= 1'b0;
      cmdReady <= 1'b0;
      rdValid <= 1'b0;
      rdLast <= 1'b0;
      rdData <= 8'h00;
      byteIdx <= 5'h00;
    end else begin
      lstate <= next_lstate;
      hCode <= next_hCode;
      hData <= next_hData;
      reqToggle <= next_reqToggle;
      ackSeen <= next_ackSeen;
      cmdReady <= next_cmdReady;
      rdValid <= next_rdValid;
      rdLast <= next_rdLast;
      rdData <= next_rdData;
      byteIdx <= next_byteIdx;
    end
  end
  fps_core_t state, next_state;
  logic reqS1, reqS2, reqSeen, dvS1, dvS2, uvS1, uvS2;
  logic [CW-1:0] commitCnt, next_commitCnt;
  logic [REC_BITS-1:0] ramRecord, flashRecord, next_ramRecord, next_readBuf;
  logic next_reqSeen, next_ackToggle, next_captureOn, next_commitBusy;
  logic next_nvmLoad, next_nvmStore, next_restoreRefused, newReq, takeReq, commitStart;
  logic [1:0] next_nvmSel, next_activeConfig;
  // A capture control request waits while a commit runs
  assign newReq = reqS2 ^ reqSeen;
  assign takeReq = newReq && (state == ST_IDLE ||
                   (state == ST_COMMIT && hCode != CMD_CAPTURE_CONTROL));
  // Commit on shutdown fault or host request with output off; retry faults skip it
  assign commitStart = (state == ST_IDLE) &&
    ((faultEvent && faultShutdown) ||
     (takeReq && hCode == CMD_CAPTURE_CONTROL && hData == CTL_COMMIT && !outputEnabled));
  // Core next-state: init check, capture refresh, command execution, commit timer
  always_comb begin
    next_state = state;
    next_commitCnt = commitCnt;
    next_ramRecord = ramRecord;
    next_readBuf = readBuf;
    next_reqSeen = takeReq ? reqS2 : reqSeen;
    next_ackToggle = takeReq ? ~ackToggle : ackToggle;
    next_captureOn = captureOn;
    next_commitBusy = commitBusy;
    next_nvmLoad = 1'b0;
    next_nvmStore = 1'b0;
    next_nvmSel = nvmSel;
    next_activeConfig = activeConfig;
    next_restoreRefused = 1'b0;
    if (captureOn && fwTick && state != ST_INIT) begin
      next_ramRecord = liveRec;
    end
    unique case (state)
      ST_INIT: begin
        // Look for stored settings, user store first
        next_nvmLoad = dvS2 | uvS2;
        next_nvmSel = uvS2 ? CFG_USER : (dvS2 ? CFG_DEFAULT : CFG_NONE);
        next_activeConfig = next_nvmSel;
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (commitStart) begin
          next_state = ST_COMMIT;
          next_commitCnt = '0;
          next_commitBusy = 1'b1;
        end
      end
      ST_COMMIT: begin
        next_commitCnt = commitCnt + CW'(1);
        if (commitCnt == CW'(COMMIT_CYC - 1)) begin
          next_state = ST_IDLE;
          next_commitBusy = 1'b0;
        end
      end
      default: next_state = ST_INIT;
    endcase
    if (takeReq) begin
      unique case (hCode)
        CMD_MISC_CONFIG: next_captureOn = hData[CAPTURE_EN_BIT];
        CMD_CAPTURE_CONTROL: begin
          if (hData == CTL_LOAD_FROM_FLASH) begin
            next_ramRecord = flashRecord;
          end
        end
        CMD_CAPTURE_READ: next_readBuf = ramRecord;
        CMD_TELEM_READ: next_readBuf = liveRec;
        CMD_RESTORE_DEFAULT, CMD_RESTORE_USER: begin
          if (levelAllowed[(hCode == CMD_RESTORE_USER) ? LVL_USER_BIT : LVL_DEFAULT_BIT]) begin
            next_nvmLoad = 1'b1;
            next_nvmSel = (hCode == CMD_RESTORE_USER) ? CFG_USER : CFG_DEFAULT;
            next_activeConfig = next_nvmSel;
          end else begin
            next_restoreRefused = 1'b1;
          end
        end
        CMD_STORE_DEFAULT, CMD_STORE_USER: begin
          next_nvmStore = 1'b1;
          next_nvmSel = (hCode == CMD_STORE_USER) ? CFG_USER : CFG_DEFAULT;
        end
        default: ;
      endcase
    end
  end
  // Core registers; store-valid pins pass two flops first
  always_ff @(posedge clock) begin
    reqS1 <= reqToggle;
    reqS2 <= reqS1;
    dvS1 <= defaultStoreValid;
    dvS2 <= dvS1;
    uvS1 <= userStoreValid;
    uvS2 <= uvS1;
    if (!rst_b) begin
      state <= ST_INIT;
      commitCnt <= '0;
      ramRecord <= REC_RESET;
      readBuf <= REC_RESET;
      reqSeen <= 1'b0;
      ackToggle <= 1'b0;
      captureOn <= CAPTURE_RESET;
      commitBusy <= 1'b0;
      nvmLoad <= 1'b0;
      nvmStore <= 1'b0;
      nvmSel <= CFG_NONE;
      activeConfig <= CFG_NONE;
      restoreRefused <= 1'b0;
    end else begin
      state <= next_state;
      commitCnt <= next_commitCnt;
      ramRecord <= next_ramRecord;
      readBuf <= next_readBuf;
      reqSeen <= next_reqSeen;
      ackToggle <= next_ackToggle;
      captureOn <= next_captureOn;
      commitBusy <= next_commitBusy;
      nvmLoad <= next_nvmLoad;
      nvmStore <= next_nvmStore;
      nvmSel <= next_nvmSel;
      activeConfig <= next_activeConfig;
      restoreRefused <= next_restoreRefused;
    end
  end
  // Flash image is deliberately not reset so it outlives a power cycle
  always_ff @(posedge clock) begin
    if (commitStart) begin
      flashRecord <= ramRecord;
    end
  end
  // Checks; takeMisc marks a capture-mode write being taken
  wire logic takeMisc = takeReq && hCode == CMD_MISC_CONFIG;
  property p_capture_set;
    @(posedge clock) disable iff (!rst_b)
    takeMisc |=> captureOn == $past(hData[CAPTURE_EN_BIT]);
  endproperty
  a_capture_set: assert property (p_capture_set) else $error("capture mode not set");
  property p_refresh;
    @(posedge clock) disable iff (!rst_b)
    (captureOn && fwTick && state != ST_INIT && !takeReq) |=> ramRecord == $past(liveRec);
  endproperty
  a_refresh: assert property (p_refresh) else $error("record not refreshed");
  property p_frozen;
    @(posedge clock) disable iff (!rst_b)
    (!captureOn && !takeReq) |=> $stable(ramRecord);
  endproperty
  a_frozen: assert property (p_frozen) else $error("record changed with capture off");
  property p_commit_blocked;
    @(posedge clock) disable iff (!rst_b)
    (state == ST_IDLE && outputEnabled && !faultEvent) |=> state != ST_COMMIT;
  endproperty
  a_commit_blocked: assert property (p_commit_blocked) else $error("commit while enabled");
  property p_fault_commit;
    @(posedge clock) disable iff (!rst_b)
    (state == ST_IDLE && faultEvent && faultShutdown) |=> commitBusy && flashRecord == $past(ramRecord);
  endproperty
  a_fault_commit: assert property (p_fault_commit) else $error("shutdown fault not committed");
  property p_retry_skip;
    @(posedge clock) disable iff (!rst_b)
    (state == ST_IDLE && faultEvent && !faultShutdown && !(takeReq && hCode == CMD_CAPTURE_CONTROL))
      |=> state == ST_IDLE;
  endproperty
  a_retry_skip: assert property (p_retry_skip) else $error("retry fault committed");
  property p_commit_time;
    @(posedge clock) disable iff (!rst_b)
    state == ST_COMMIT |-> commitCnt < CW'(COMMIT_CYC);
  endproperty
  a_commit_time: assert property (p_commit_time) else $error("commit overran");
  property p_defer;
    @(posedge clock) disable iff (!rst_b)
    (state == ST_COMMIT && newReq && hCode == CMD_CAPTURE_CONTROL) |=> $stable(ackToggle);
  endproperty
  a_defer: assert property (p_defer) else $error("control taken during commit");
  property p_restore_block;
    @(posedge clock) disable iff (!rst_b)
    (takeReq && hCode == CMD_RESTORE_DEFAULT && !levelAllowed[LVL_DEFAULT_BIT])
      |=> restoreRefused && !nvmLoad;
  endproperty
  a_restore_block: assert property (p_restore_block) else $error("blocked restore ran");
  sequence s_burst_end;
    (rdValid && rdLast) ##1 (!rdValid && cmdReady);
  endsequence
  property p_block_read;
    @(posedge linkClk) disable iff (!lrs2)
    $rose(rdValid) |-> !cmdReady ##31 s_burst_end;
  endproperty
  a_block_read: assert property (p_block_read) else $error("block read not 32 bytes");
endmodule // fps_capture_record_read_cmd_store
`default_nettype wire

// >>> hw/fps_pkg.sv
// Constants and types for the fault parameter capture_record_read_cmd store
package fps_pkg;
  // Record geometry
  localparam int REC_BYTES = 32;
  localparam int REC_BITS = REC_BYTES * 8;
  localparam int TELEM_BITS = 96;
  // Host command codes
  localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_TELEM_READ = 8'hd0;
  localparam logic [7:0] CMD_MISC_CONFIG = 8'he9;
  localparam logic [7:0] CMD_CAPTURE_CONTROL = 8'hea;
  localparam logic [7:0] CMD_CAPTURE_READ = 8'heb;
  // Misc configuration field position
  localparam int CAPTURE_EN_BIT = 1;
  // Capture control values
  localparam logic [7:0] CTL_LOAD_FROM_FLASH = 8'h01;
  localparam logic [7:0] CTL_COMMIT = 8'h02;
  // Restore permission mask positions
  localparam int LVL_DEFAULT_BIT = 0;
  localparam int LVL_USER_BIT = 1;
  // Reset values
  localparam logic CAPTURE_RESET = 1'b0;
  localparam logic [REC_BITS-1:0] REC_RESET = {REC_BITS{1'b0}};
  // Flash commit time, longest allowed, rounded down to clock cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int COMMIT_TIME_US = 1400;
  localparam int COMMIT_CYCLES = (COMMIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int BYTE_IDX_LAST = REC_BYTES - 1;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_COMMIT = 2'b10
  } fps_core_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_WAIT = 2'b01,
    LK_SEND = 2'b10
  } fps_link_t;

  typedef enum logic [1:0] {
    CFG_NONE = 2'b00,
    CFG_DEFAULT = 2'b01,
    CFG_USER = 2'b10
  } fps_cfg_t;
endpackage

// >>> bench/fps_host_model.sv
// Host controller model driving the command link of the capture_record_read_cmd store
`timescale 1ns/1ps
`default_nettype none
module fps_host_model (
  input wire logic linkClk, // Link clock
  output logic cmdValid, // Command strobe
  output logic [7:0] cmdCode, // Command code
  output logic [7:0] cmdData, // Command data
  input wire logic cmdReady, // Link free
  input wire logic rdValid, // Read byte valid
  input wire logic [7:0] rdData, // Read byte
  input wire logic rdLast // Last byte of block
);
  logic [7:0] rx[32];
  int rxN;
  int lastAt;
  logic hang;
  // Idle link at time zero
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdData = 8'h00;
    hang = 1'b0;
  end
  // One command; request held until ready is seen, then whole block taken
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge linkClk);
    #1;
    cmdValid = 1'b1;
    cmdCode = code;
    cmdData = data;
    do begin
      @(posedge linkClk);
      n++;
    end while (cmdReady !== 1'b1 && n < 3000);
    #1;
    cmdValid = 1'b0;
    cmdCode = ~code; // Released lines must not keep a stale value
    cmdData = ~data;
    rxN = 0;
    lastAt = 0;
    // Bus stays occupied until the last byte; nothing issued meanwhile
    do begin
      @(posedge linkClk);
      n++;
      if (rdValid === 1'b1 && rxN < 32) begin
        rx[rxN] = rdData;
        rxN++;
        if (rdLast === 1'b1) lastAt = rxN;
      end
    end while (cmdReady !== 1'b1 && n < 6000);
    if (cmdReady !== 1'b1) hang = 1'b1;
  endtask
endmodule // fps_host_model
`default_nettype wire

// >>> bench/fps_capture_record_read_cmd_store_test.sv
// Self-checking testbench for the capture_record_read_cmd store
`timescale 1ns/1ps
`default_nettype none
module fps_capture_record_read_cmd_store_test;
  import fps_pkg::*;
  localparam int CYC = 20; // Short commit keeps the run brief
  logic clock, rst_b, linkClk, fwTick, outputEnabled, faultEvent, faultShutdown, capM;
  logic defaultStoreValid, userStoreValid;
  logic [1:0] levelAllowed;
  logic [15:0] vin, vout, iout, temp, freq, duty;
  wire logic cmdValid, cmdReady, rdValid, rdLast, captureOn, commitBusy;
  wire logic nvmLoad, nvmStore, restoreRefused;
  wire logic [7:0] cmdCode, cmdData, rdData;
  wire logic [1:0] nvmSel, activeConfig;
  int error_cnt, cmp_count, loadCnt, storeCnt, refuseCnt, busyLen;
  int ram[32], flash[32];

  fps_capture_record_read_cmd_store #(.COMMIT_CYC(CYC)) dut_u (.clock(clock), .rst_b(rst_b),
    .linkClk(linkClk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
    .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .rdLast(rdLast),
    .fwTick(fwTick), .outputEnabled(outputEnabled), .faultEvent(faultEvent),
    .faultShutdown(faultShutdown), .levelAllowed(levelAllowed),
    .defaultStoreValid(defaultStoreValid), .userStoreValid(userStoreValid),
    .vin(vin), .vout(vout), .iout(iout), .temp(temp), .freq(freq), .duty(duty),
    .captureOn(captureOn), .commitBusy(commitBusy), .nvmLoad(nvmLoad),
    .nvmStore(nvmStore), .nvmSel(nvmSel), .activeConfig(activeConfig),
    .restoreRefused(restoreRefused));
  fps_host_model host_u (.linkClk(linkClk), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
    .rdLast(rdLast));

  // Core clock 40 ns, link clock 32 ns with an odd phase
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #16 linkClk = ~linkClk;
  end
  // Pulse and busy counters, sampled where outputs are settled
  always @(posedge clock) begin
    if (nvmLoad === 1'b1) loadCnt++;
    if (nvmStore === 1'b1) storeCnt++;
    if (restoreRefused === 1'b1) refuseCnt++;
    if (commitBusy === 1'b1) busyLen++;
  end
  // A stuck link is a failure, not a hang
  always @(posedge host_u.hang) begin
    error_cnt++;
    close_out();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Record byte k as the live telemetry would give it, little-endian
  function automatic int lb(input int k);
    logic [95:0] t;
    t = {duty, freq, temp, iout, vout, vin};
    return (k < 12) ? int'(t[8*k +: 8]) : 0;
  endfunction
  task automatic tick(); // Firmware cycle; model refreshes only with capture on
    @(negedge clock);
    fwTick = 1'b1;
    @(negedge clock);
    fwTick = 1'b0;
    if (capM) for (int k = 0; k < 32; k++) ram[k] = lb(k);
  endtask
  // Command through the host; the model applies a commit before it, other effects after
  task automatic cmd(input logic [7:0] code, input logic [7:0] data);
    if (code == CMD_CAPTURE_CONTROL && data == CTL_COMMIT && !outputEnabled) flash = ram;
    host_u.send(code, data);
    repeat (3) @(negedge clock);
    if (code == CMD_MISC_CONFIG) capM = data[CAPTURE_EN_BIT];
    if (code == CMD_CAPTURE_CONTROL && data == CTL_LOAD_FROM_FLASH) ram = flash;
  endtask
  task automatic read_chk(input string what);
    cmd(CMD_CAPTURE_READ, 8'h00);
    check({what, " count"}, host_u.rxN, 32);
    check({what, " last"}, host_u.lastAt, 32);
    for (int k = 0; k < 32; k++) check(what, host_u.rx[k], ram[k]);
  endtask
  task automatic fault(input logic shut);
    @(negedge clock);
    faultShutdown = shut;
    faultEvent = 1'b1;
    @(negedge clock);
    faultEvent = 1'b0;
    if (shut) flash = ram;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (commitBusy !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (commitBusy !== 1'b0) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic do_reset(); // Reset as a power cycle; flash is kept
    @(negedge clock);
    rst_b = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    capM = 1'b0;
    ram = '{default: 0};
  endtask
  task automatic capture_new(); // Fresh values into RAM, then capture off
    cmd(CMD_MISC_CONFIG, 8'h02);
    {vin, vout, iout, temp, freq, duty} = {$urandom, $urandom, $urandom};
    tick();
    cmd(CMD_MISC_CONFIG, 8'h00);
  endtask

  // Main sequence
  initial begin
    {fwTick, faultEvent, faultShutdown, userStoreValid, rst_b, capM} = '0;
    {error_cnt, cmp_count, loadCnt, storeCnt, refuseCnt, busyLen} = '0;
    {vin, vout, iout, temp, freq, duty} = '0;
    defaultStoreValid = 1'b1;
    outputEnabled = 1'b1;
    levelAllowed = 2'b01;
    void'($urandom(15));
    do_reset();
    check("activeConfig", activeConfig, CFG_DEFAULT);
    check("loadCnt", loadCnt, 1);
    $display("test init done");
    cmd(CMD_MISC_CONFIG, 8'h02);
    check("captureOn", captureOn, 1);
    {vin, vout, iout, temp, freq, duty} = {$urandom, $urandom, $urandom};
    tick();
    read_chk("live record");
    cmd(CMD_MISC_CONFIG, 8'hfd); // Every bit set except bit 1
    check("captureOn", captureOn, 0);
    {vin, vout, iout, temp, freq, duty} = {$urandom, $urandom, $urandom};
    tick();
    read_chk("frozen record");
    {vin, vout, iout, temp, freq, duty} = {$urandom, $urandom, $urandom};
    cmd(CMD_TELEM_READ, 8'h00);
    check("telemetry count", host_u.rxN, 32);
    for (int k = 0; k < 32; k++) check("telemetry", host_u.rx[k], lb(k));
    $display("test capture done");
    fault(1'b0);
    repeat (4) @(negedge clock);
    check("retry busy", busyLen, 0);
    fault(1'b1);
    cmd(CMD_CAPTURE_CONTROL, CTL_LOAD_FROM_FLASH);
    check("commitBusy", commitBusy, 0);
    check("commit ran", busyLen > 0, 1);
    check("commit time", busyLen <= CYC, 1);
    read_chk("during regulation");
    capture_new();
    outputEnabled = 1'b0; // Host order: capture off, output off, load, read
    userStoreValid = 1'b1;
    do_reset();
    check("activeConfig", activeConfig, CFG_USER);
    cmd(CMD_CAPTURE_CONTROL, CTL_LOAD_FROM_FLASH);
    read_chk("after power cycle");
    $display("test fault done");
    outputEnabled = 1'b1;
    capture_new();
    busyLen = 0;
    cmd(CMD_CAPTURE_CONTROL, CTL_COMMIT);
    check("enabled commit", busyLen, 0);
    outputEnabled = 1'b0;
    cmd(CMD_CAPTURE_CONTROL, CTL_COMMIT);
    wait_idle();
    check("disabled commit", busyLen > 0, 1);
    capture_new();
    cmd(CMD_CAPTURE_CONTROL, CTL_LOAD_FROM_FLASH);
    read_chk("commanded commit");
    $display("test commit done");
    loadCnt = 0;
    cmd(CMD_RESTORE_DEFAULT, 8'h00);
    check("default load", loadCnt, 1);
    check("activeConfig", activeConfig, CFG_DEFAULT);
    levelAllowed = 2'b10;
    cmd(CMD_RESTORE_DEFAULT, 8'h00);
    check("refused", refuseCnt, 1);
    check("no load", loadCnt, 1);
    cmd(CMD_RESTORE_USER, 8'h00);
    check("activeConfig", activeConfig, CFG_USER);
    cmd(CMD_STORE_USER, 8'h00); // Saves settings to the user store even with capture off
    check("store pulse", storeCnt, 1);
    check("nvmSel", nvmSel, CFG_USER);
    cmd(CMD_STORE_DEFAULT, 8'h00);
    check("store pulses", storeCnt, 2);
    check("nvmSel", nvmSel, CFG_DEFAULT);
    $display("test restore done");
    close_out();
  end
endmodule // fps_capture_record_read_cmd_store_test
`default_nettype wire
